//--- pkg/lsbf_pkg.sv
// Package for the LED sink blink/fade control register bank.
// Assumes a single 25 MHz clock and a byte-wide register port.
package lsbf_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    // Blink timebase: every on/off time is a whole number of these steps
    localparam int unsigned TICK_TIME_MS  = 200;
    localparam int unsigned TICK_CYCLES_DEF = (CLK_HZ / 1000) * TICK_TIME_MS;

    // Register offsets
    localparam logic [7:0] ADDR_DARK_DIM_CURRENT = 8'h0E;
    localparam logic [7:0] ADDR_SINK_FADE_LAW    = 8'h0F;
    localparam logic [7:0] ADDR_SINK_ENABLE_CTRL = 8'h10;
    localparam logic [7:0] ADDR_SINK_BLINK_A     = 8'h11;
    localparam logic [7:0] ADDR_SINK_BLINK_B     = 8'h12;

    // Field layout
    localparam int unsigned NUM_SINKS     = 7;
    localparam int unsigned DIM_CODE_W    = 7;
    localparam int unsigned LAW_W         = 2;
    localparam int unsigned CODE_W        = 2;
    localparam int unsigned ON_TIME_LSB   = 6;
    localparam int unsigned FIRST_A_SINK  = 4; // Sinks 5..7 live in time_a
    localparam int unsigned CNT_W         = 4;

    // Reset values
    localparam logic [7:0] RST_REG        = 8'h00;

    // Fade laws
    localparam logic [1:0] LAW_LIN_LIN    = 2'h0;
    localparam logic [1:0] LAW_SQR_LIN    = 2'h1;
    localparam logic [1:0] LAW_SQR_CUB10  = 2'h2;
    localparam logic [1:0] LAW_SQR_CUB11  = 2'h3;

    // On and off times in milliseconds
    localparam int unsigned ON_MS_0  = 200;
    localparam int unsigned ON_MS_1  = 600;
    localparam int unsigned ON_MS_2  = 800;
    localparam int unsigned ON_MS_3  = 1200;
    localparam int unsigned OFF_MS_1 = 600;
    localparam int unsigned OFF_MS_2 = 1200;
    localparam int unsigned OFF_MS_3 = 1800;

    localparam logic [3:0] ON_TK_0  = 4'(ON_MS_0 / TICK_TIME_MS);
    localparam logic [3:0] ON_TK_1  = 4'(ON_MS_1 / TICK_TIME_MS);
    localparam logic [3:0] ON_TK_2  = 4'(ON_MS_2 / TICK_TIME_MS);
    localparam logic [3:0] ON_TK_3  = 4'(ON_MS_3 / TICK_TIME_MS);
    localparam logic [3:0] OFF_TK_1 = 4'(OFF_MS_1 / TICK_TIME_MS);
    localparam logic [3:0] OFF_TK_2 = 4'(OFF_MS_2 / TICK_TIME_MS);
    localparam logic [3:0] OFF_TK_3 = 4'(OFF_MS_3 / TICK_TIME_MS);
    localparam logic [1:0] OFF_DISABLED = 2'h0;
endpackage

//--- logic/lsbf_ctrl.sv
// Register bank and blink sequencer for seven LED current sinks plus
// the dark-level dim current selection.
// Assumes the two-wire host front end delivers byte reads and writes on
// the i_REG_* port, all in the I_CLOCK domain.
// The blink tick length is a parameter so a bench can shorten it.
module lsbf_ctrl
    import lsbf_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic                  I_CLOCK,
    input  wire logic                  I_SYS_RST,
    // Register port
    input  wire logic [7:0]            i_REG_ADDR,
    input  wire logic [7:0]            i_REG_WDATA,
    input  wire logic                  i_REG_WR,
    input  wire logic                  i_REG_RD,
    output logic      [7:0]            o_REG_RDATA,
    // Dark level selection
    input  wire logic                  i_DIM_ENABLE,
    input  wire logic                  i_DIM_TIMEOUT,
    input  wire logic [DIM_CODE_W-1:0] i_DARK_MAX_CODE,
    output logic      [DIM_CODE_W-1:0] o_DARK_LEVEL_CODE,
    // Sink controls
    output logic      [LAW_W-1:0]      o_SINK_LAW,
    output logic                       o_SQUARE_LAW_DAC,
    output logic                       o_NONLINEAR_STEPS,
    output logic      [NUM_SINKS-1:0]  o_SINK_ON
);
    // Prescaler wide enough to count up to TICK_CYCLES-1
    localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRESC_LAST = PW'(TICK_CYCLES - 1);

    typedef struct packed {
        logic [DIM_CODE_W-1:0]            dim_code;
        logic [LAW_W-1:0]                 law;
        logic [NUM_SINKS-1:0]             enable;
        logic [7:0]                       time_a;
        logic [7:0]                       time_b;
        logic [PW-1:0]                    presc;
        logic [NUM_SINKS-1:0]             off_phase;
        logic [NUM_SINKS-1:0][CNT_W-1:0]  cnt;
        logic [7:0]                       rdata;
        logic [DIM_CODE_W-1:0]            dark_code;
        logic [NUM_SINKS-1:0]             sink_on;
        logic                             square_dac;
        logic                             nonlinear;
    } lsbf_state_t;

    lsbf_state_t state;
    lsbf_state_t next_state;

    // Register picked by an offset. Writes and reads both decode through
    // reg_sel, so the two maps cannot drift apart when one is edited.
    typedef enum {
        LSBF_SEL_NONE,
        LSBF_SEL_DIM,
        LSBF_SEL_LAW,
        LSBF_SEL_ENABLE,
        LSBF_SEL_TIME_A,
        LSBF_SEL_TIME_B
    } lsbf_sel_t;

    function automatic lsbf_sel_t reg_sel(input logic [7:0] addr);
        case (addr)
            ADDR_DARK_DIM_CURRENT: reg_sel = LSBF_SEL_DIM;
            ADDR_SINK_FADE_LAW:    reg_sel = LSBF_SEL_LAW;
            ADDR_SINK_ENABLE_CTRL: reg_sel = LSBF_SEL_ENABLE;
            ADDR_SINK_BLINK_A:     reg_sel = LSBF_SEL_TIME_A;
            ADDR_SINK_BLINK_B:     reg_sel = LSBF_SEL_TIME_B;
            default:               reg_sel = LSBF_SEL_NONE;
        endcase
    endfunction

    function automatic logic [3:0] on_ticks(input logic [1:0] code);
        case (code)
            2'h0:    on_ticks = ON_TK_0;
            2'h1:    on_ticks = ON_TK_1;
            2'h2:    on_ticks = ON_TK_2;
            default: on_ticks = ON_TK_3;
        endcase
    endfunction

    function automatic logic [3:0] off_ticks(input logic [1:0] code);
        case (code)
            2'h1:    off_ticks = OFF_TK_1;
            2'h2:    off_ticks = OFF_TK_2;
            default: off_ticks = OFF_TK_3;
        endcase
    endfunction

    // Off code of sink index i (0 = sink 1)
    function automatic logic [1:0] off_code(input int unsigned i,
                                            input logic [7:0] ta,
                                            input logic [7:0] tb);
        logic [3:0] sa;
        sa = 4'(i - FIRST_A_SINK);
        if (i >= FIRST_A_SINK) begin
            off_code = ta[sa*CODE_W +: CODE_W];
        end else begin
            off_code = tb[i*CODE_W +: CODE_W];
        end
    endfunction

    // Length in ticks of the phase a sink is in. The off phase uses the
    // sink's own code, the on phase the code shared by all sinks.
    function automatic logic [3:0] phase_ticks(input logic       off_ph,
                                               input logic [1:0] on_sel,
                                               input logic [1:0] off_sel);
        if (off_ph) begin
            phase_ticks = off_ticks(off_sel);
        end else begin
            phase_ticks = on_ticks(on_sel);
        end
    endfunction

    always_comb begin
        logic [NUM_SINKS-1:0] new_en;
        logic                 tick;
        logic [1:0]           oc;
        logic [3:0]           limit;
        logic [1:0]           on_code;
        logic                 use_dim;
        new_en     = '0;
        tick       = 1'b0;
        oc         = OFF_DISABLED;
        limit      = '0;
        on_code    = state.time_a[ON_TIME_LSB +: CODE_W];
        use_dim    = i_DIM_ENABLE || i_DIM_TIMEOUT;
        next_state = state;

        // Register writes; reserved bits are dropped here
        if (i_REG_WR) begin
            case (reg_sel(i_REG_ADDR))
                LSBF_SEL_DIM: begin
                    next_state.dim_code =
                        i_REG_WDATA[DIM_CODE_W-1:0];
                end
                LSBF_SEL_LAW: begin
                    next_state.law =
                        i_REG_WDATA[LAW_W-1:0];
                end
                LSBF_SEL_ENABLE: begin
                    next_state.enable =
                        i_REG_WDATA[NUM_SINKS-1:0];
                    // Only 0 to 1 edges restart a sequence
                    new_en = i_REG_WDATA[NUM_SINKS-1:0] & ~state.enable;
                end
                LSBF_SEL_TIME_A: begin
                    next_state.time_a = i_REG_WDATA;
                end
                LSBF_SEL_TIME_B: begin
                    next_state.time_b = i_REG_WDATA;
                end
                default: begin
                    // Unmapped offsets take no write
                end
            endcase
        end

        // Register reads, one cycle of latency; unmapped reads give zero
        if (i_REG_RD) begin
            case (reg_sel(i_REG_ADDR))
                LSBF_SEL_DIM: begin
                    next_state.rdata = {1'b0, state.dim_code};
                end
                LSBF_SEL_LAW: begin
                    next_state.rdata = {6'h00, state.law};
                end
                LSBF_SEL_ENABLE: begin
                    next_state.rdata = {1'b0, state.enable};
                end
                LSBF_SEL_TIME_A: begin
                    next_state.rdata = state.time_a;
                end
                LSBF_SEL_TIME_B: begin
                    next_state.rdata = state.time_b;
                end
                default: begin
                    next_state.rdata = 8'h00;
                end
            endcase
        end

        // Shared timebase; a fresh enable restarts it so that the first
        // on phase is full length. Sinks already blinking may see one
        // step stretched by this, traded for a single prescaler.
        if (new_en != '0) begin
            next_state.presc = '0;
        end else if (state.presc == PRESC_LAST) begin
            next_state.presc = '0;
            tick = 1'b1;
        end else begin
            next_state.presc = state.presc + PW'(1);
        end

        // Each sink restarts, stays on, or steps through on and off phases
        for (int unsigned i = 0; i < NUM_SINKS; i++) begin
            oc = off_code(i, next_state.time_a, next_state.time_b);
            if (new_en[i] || !next_state.enable[i]) begin
                next_state.off_phase[i] = 1'b0;
                next_state.cnt[i]       = '0;
            end else if (oc == OFF_DISABLED) begin
                next_state.off_phase[i] = 1'b0;
                next_state.cnt[i]       = '0;
            end else if (tick) begin
                // Phase length is taken from the phase now ending
                limit = phase_ticks(state.off_phase[i], on_code, oc);
                if (state.cnt[i] + 4'h1 >= limit) begin
                    next_state.off_phase[i] =
                        ~state.off_phase[i];
                    next_state.cnt[i]       = '0;
                end else begin
                    next_state.cnt[i] = state.cnt[i] + 4'h1;
                end
            end
        end

        // Enable gates everything; blinking only masks within it
        next_state.sink_on =
            next_state.enable & ~next_state.off_phase;

        // The dim select is a level, so the dark code follows it one
        // clock later and holds while it stays up
        if (use_dim) begin
            next_state.dark_code = state.dim_code;
        end else begin
            next_state.dark_code = i_DARK_MAX_CODE;
        end

        // Decode the law being written, so the flags never lag the
        // registered law output by a cycle
        case (next_state.law)
            LAW_LIN_LIN: begin
                next_state.square_dac = 1'b0;
                next_state.nonlinear  = 1'b0;
            end
            LAW_SQR_LIN: begin
                next_state.square_dac = 1'b1;
                next_state.nonlinear  = 1'b0;
            end
            LAW_SQR_CUB10: begin
                next_state.square_dac = 1'b1;
                next_state.nonlinear  = 1'b1;
            end
            LAW_SQR_CUB11: begin
                next_state.square_dac = 1'b1;
                next_state.nonlinear  = 1'b1;
            end
            default: begin
                next_state.square_dac = 1'b0;
                next_state.nonlinear  = 1'b0;
            end
        endcase
    end

    // The whole record clears first; register fields then take their
    // reset value, so a changed reset value touches one line only
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            state           <= '0;
            state.dim_code  <= RST_REG[DIM_CODE_W-1:0];
            state.law       <= RST_REG[LAW_W-1:0];
            state.enable    <= RST_REG[NUM_SINKS-1:0];
            state.time_a    <= RST_REG;
            state.time_b    <= RST_REG;
        end else begin
            state <= next_state;
        end
    end

    // Every output comes straight from a flop of the state record
    assign o_REG_RDATA       = state.rdata;
    assign o_DARK_LEVEL_CODE = state.dark_code;
    assign o_SINK_LAW        = state.law;
    assign o_SQUARE_LAW_DAC  = state.square_dac;
    assign o_NONLINEAR_STEPS = state.nonlinear;
    assign o_SINK_ON         = state.sink_on;
endmodule

//--- tb/lsbf_ctrl_asserts.sv
// Port-level checker for the sink control bank, bound to lsbf_ctrl.
// Assumes one clock domain and the register offsets of lsbf_pkg.
module lsbf_ctrl_asserts
    import lsbf_pkg::*;
(
    input wire logic       I_CLOCK,
    input wire logic       I_SYS_RST,
    input wire logic [7:0] i_REG_ADDR,
    input wire logic [7:0] i_REG_WDATA,
    input wire logic       i_REG_WR,
    input wire logic       i_REG_RD,
    input wire logic [7:0] o_REG_RDATA,
    input wire logic       i_DIM_ENABLE,
    input wire logic       i_DIM_TIMEOUT,
    input wire logic [6:0] i_DARK_MAX_CODE,
    input wire logic [6:0] o_DARK_LEVEL_CODE,
    input wire logic [1:0] o_SINK_LAW,
    input wire logic       o_SQUARE_LAW_DAC,
    input wire logic       o_NONLINEAR_STEPS,
    input wire logic [6:0] o_SINK_ON
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);
    // Shadows of the enable and dim registers, rebuilt from the writes
    logic [6:0] en_q;
    logic [6:0] dim_q;
    wire  [6:0] new_mask = i_REG_WDATA[6:0] & ~en_q;
    wire        wr_en = i_REG_WR && i_REG_ADDR == ADDR_SINK_ENABLE_CTRL;
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            en_q <= 7'h00;
            dim_q <= 7'h00;
        end else begin
            if (wr_en) en_q <= i_REG_WDATA[6:0];
            if (i_REG_WR && i_REG_ADDR == ADDR_DARK_DIM_CURRENT)
                dim_q <= i_REG_WDATA[6:0];
        end
    end
    chk_dim_resv: assert property (i_REG_RD &&
        i_REG_ADDR == ADDR_DARK_DIM_CURRENT |=> !o_REG_RDATA[7])
        else $error("dim register bit 7 reads one");
    chk_law_resv: assert property (i_REG_RD &&
        i_REG_ADDR == ADDR_SINK_FADE_LAW |=> o_REG_RDATA[7:2] == 6'h00)
        else $error("law register reserved bits read nonzero");
    chk_en_resv: assert property (i_REG_RD &&
        i_REG_ADDR == ADDR_SINK_ENABLE_CTRL |=> !o_REG_RDATA[7])
        else $error("enable register bit 7 reads one");
    chk_unmapped_zero: assert property (i_REG_RD &&
        (i_REG_ADDR < 8'h0E || i_REG_ADDR > 8'h12) |=> o_REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    chk_law_square: assert property (
        o_SQUARE_LAW_DAC == (o_SINK_LAW != 2'h0))
        else $error("square law flag does not match law");
    chk_law_cubic: assert property (
        o_NONLINEAR_STEPS == o_SINK_LAW[1])
        else $error("nonlinear step flag does not match law");
    chk_dark_max: assert property (!(i_DIM_ENABLE || i_DIM_TIMEOUT)
        |=> o_DARK_LEVEL_CODE == $past(i_DARK_MAX_CODE))
        else $error("dark level not at max code");
    chk_dark_dim: assert property ((i_DIM_ENABLE || i_DIM_TIMEOUT)
        |=> o_DARK_LEVEL_CODE == $past(dim_q))
        else $error("dark level not at dim code");
    chk_sink_off: assert property ((o_SINK_ON & ~en_q) == 7'h00)
        else $error("disabled sink is on");
    chk_new_on: assert property (wr_en
        |=> (o_SINK_ON & $past(new_mask)) == $past(new_mask))
        else $error("newly enabled sink did not start on");
endmodule

bind lsbf_ctrl lsbf_ctrl_asserts u_chk (
    .I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST), .i_REG_ADDR(i_REG_ADDR),
    .i_REG_WDATA(i_REG_WDATA), .i_REG_WR(i_REG_WR), .i_REG_RD(i_REG_RD),
    .o_REG_RDATA(o_REG_RDATA), .i_DIM_ENABLE(i_DIM_ENABLE),
    .i_DIM_TIMEOUT(i_DIM_TIMEOUT), .i_DARK_MAX_CODE(i_DARK_MAX_CODE),
    .o_DARK_LEVEL_CODE(o_DARK_LEVEL_CODE), .o_SINK_LAW(o_SINK_LAW),
    .o_SQUARE_LAW_DAC(o_SQUARE_LAW_DAC),
    .o_NONLINEAR_STEPS(o_NONLINEAR_STEPS), .o_SINK_ON(o_SINK_ON));

//--- tb/lsbf_led_model.sv
// LED model: records the length of the last on and off run of each sink.
// Assumes sink outputs are synchronous to clk.
module lsbf_led_model (
    input  wire logic        clk,
    input  wire logic [6:0]  sink_on,
    output logic      [15:0] on_len [7],
    output logic      [15:0] off_len [7]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] run [7];
    logic [6:0]  prev = 7'h00;
    always @(posedge clk) begin
        prev <= sink_on;
        for (int i = 0; i < 7; i++) begin
            if (sink_on[i] !== prev[i]) begin
                run[i] <= 16'h0001;
                if (prev[i]) on_len[i] <= run[i];
                else off_len[i] <= run[i];
            end else run[i] <= run[i] + 16'h0001;
        end
    end
endmodule

//--- tb/lsbf_ctrl_tb.sv
// Self-checking bench for the sink control bank, short blink tick.
// Assumes the checker and LED model are compiled with it.
module lsbf_ctrl_tb
    import lsbf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 4;
    logic        clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        dim_en = 1'b0, dim_to = 1'b0, sq, nl;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata, v, m, w;
    logic [6:0]  max_code = 7'h00, dark, sink_on, d7;
    logic [1:0]  law, c [7];
    logic [15:0] on_len [7], off_len [7];
    logic [15:0] e16;
    int          n_fail = 0, cmp_count = 0, seed = 84597;
    lsbf_ctrl #(.TICK_CYCLES(T)) dut (.I_CLOCK(clk), .I_SYS_RST(rst),
        .i_REG_ADDR(addr), .i_REG_WDATA(wdata), .i_REG_WR(wr),
        .i_REG_RD(rd), .o_REG_RDATA(rdata), .i_DIM_ENABLE(dim_en),
        .i_DIM_TIMEOUT(dim_to), .i_DARK_MAX_CODE(max_code),
        .o_DARK_LEVEL_CODE(dark), .o_SINK_LAW(law), .o_SQUARE_LAW_DAC(sq),
        .o_NONLINEAR_STEPS(nl), .o_SINK_ON(sink_on));
    lsbf_led_model leds (.clk(clk), .sink_on(sink_on), .on_len(on_len),
        .off_len(off_len));
    initial forever #20 clk = ~clk;
    task automatic chk8(string nm, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk16(string nm, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    // Strobes drop for a cycle between accesses, never re-driven in a step
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        {addr, wdata, wr} = {a, d, 1'b1};
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {addr, rd} = {a, 1'b1};
        @(negedge clk);
        rd = 1'b0;
        d = rdata;
    endtask
    function automatic logic [7:0] mask_of(logic [7:0] a);
        case (a)
            ADDR_DARK_DIM_CURRENT, ADDR_SINK_ENABLE_CTRL: return 8'h7F;
            ADDR_SINK_FADE_LAW: return 8'h03;
            ADDR_SINK_BLINK_A, ADDR_SINK_BLINK_B: return 8'hFF;
            default: return 8'h00;
        endcase
    endfunction
    function automatic int on_tk(int s);
        return (s == 0) ? 1 : (s == 1) ? 3 : (s == 2) ? 4 : 6;
    endfunction
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #500us;
        n_fail++;
        end_of_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        for (int a = 12; a < 20; a++) begin
            rd_reg(8'(a), v);
            chk8("reset value", 8'h00, v);
        end
        // First six passes hit every offset with all ones
        for (int i = 0; i < 30; i++) begin
            m = (i < 6) ? 8'(14 + i) : 8'(14 + {$random(seed)} % 6);
            v = (i < 6) ? 8'hFF : 8'($random(seed));
            wr_reg(m, v);
            rd_reg(m, w);
            chk8("readback", v & mask_of(m), w);
        end
        for (int l = 0; l < 4; l++) begin
            wr_reg(ADDR_SINK_FADE_LAW, 8'(l) | 8'hFC);
            @(negedge clk);
            chk8("law", 8'(l), {6'h00, law});
            chk8("square dac", 8'(l != 0), {7'h00, sq});
            chk8("cubic steps", 8'(l > 1), {7'h00, nl});
        end
        d7 = 7'($random(seed));
        wr_reg(ADDR_DARK_DIM_CURRENT, {1'b1, d7});
        for (int k = 0; k < 8; k++) begin
            max_code = 7'($random(seed));
            {dim_en, dim_to} = 2'(k);
            repeat (2) @(negedge clk);
            w = {1'b0, (k % 4) ? d7 : max_code};
            chk8("dark", w, {1'b0, dark});
        end
        {dim_en, dim_to} = 2'b00;
        for (int s = 0; s < 4; s++) begin
            for (int k = 0; k < 3; k++) begin
                for (int i = 0; i < 7; i++) c[i] = 2'((i + k) % 3 + 1);
                wr_reg(ADDR_SINK_ENABLE_CTRL, 8'h00);
                wr_reg(ADDR_SINK_BLINK_A, {2'(s), c[6], c[5], c[4]});
                wr_reg(ADDR_SINK_BLINK_B, {c[3], c[2], c[1], c[0]});
                wr_reg(ADDR_SINK_ENABLE_CTRL, 8'hFF);
                chk8("start", 8'h7F, {1'b0, sink_on});
                repeat (2 * (on_tk(s) + 9) * T + 4) @(negedge clk);
                for (int i = 0; i < 7; i++) begin
                    chk16("on", 16'(on_tk(s) * T), on_len[i]);
                    e16 = 16'(3 * c[i] * T);
                    chk16("off", e16, off_len[i]);
                end
            end
        end
        wr_reg(ADDR_SINK_BLINK_A, 8'hC0);
        wr_reg(ADDR_SINK_BLINK_B, 8'h00);
        for (int i = 0; i < 10; i++) begin
            v = 8'($random(seed));
            wr_reg(ADDR_SINK_ENABLE_CTRL, v);
            repeat (7) @(negedge clk);
            chk8("steady", v & 8'h7F, {1'b0, sink_on});
        end
        end_of_test();
    end
endmodule
